// file: rtl/mfi_defines.svh
// Offsets, field positions, reset values and timing counts of the flag block
// Functional notes
// - Host holds reset pin low at least 10 us; such a pulse requests reset.
// - Management init completes within 2000 ms of power-on or reset release.
// - Any interrupt condition drives the interrupt pin low within 200 ms.
// - Flags clear on read; interrupt released within 500 us after that read.
// - Receive loss sets its flag and asserts interrupt within 100 ms.
// - Fast detection mode sets receive-loss flag within 10 ms.
// - Receive-loss indication withdrawn within 100 ms once signal returns.
// - Transmit fault sets its flag and asserts interrupt within 200 ms.
// - Any other condition sets its flag and asserts interrupt within 200 ms.
// - Setting a mask bit stops that flag interrupting within 100 ms.
// - Clearing a mask bit restores that flag's interrupt within 100 ms.
// - Transmit disable turns transmitter off in 100 ms, back on in 10 s.
`ifndef MFI_DEFINES_SVH
`define MFI_DEFINES_SVH

`define MFI_CLK_MHZ 250
`define MFI_INIT_MS 2000
`define MFI_INIT_CYC (`MFI_INIT_MS * 1000 * `MFI_CLK_MHZ)
`define MFI_RST_US 10
`define MFI_RST_CYC (`MFI_RST_US * `MFI_CLK_MHZ)
`define MFI_IRQ_ON_MS 200
`define MFI_IRQ_ON_CYC (`MFI_IRQ_ON_MS * 1000 * `MFI_CLK_MHZ)
`define MFI_IRQ_OFF_US 500
`define MFI_IRQ_OFF_CYC (`MFI_IRQ_OFF_US * `MFI_CLK_MHZ)
`define MFI_LOS_FILT 4

`define MFI_OFF_STATUS 8'h00
`define MFI_OFF_MASK 8'h04
`define MFI_OFF_CTRL 8'h08
`define MFI_OFF_STATE 8'h0c

`define MFI_CTRL_TXDIS 0
`define MFI_CTRL_FAST 1
`define MFI_ST_DONE 0
`define MFI_ST_LOS 1
`define MFI_ST_TXEN 2
`define MFI_ST_FAULT 3

`define MFI_RST_FLAGS 8'h00
`define MFI_RST_MASK 8'h00
`define MFI_RST_CTRL 2'h0

`endif

// file: rtl/mfi_pkg.sv
// Types shared by the flag and interrupt block
package mfi_pkg;

    typedef struct packed {
        logic [5:0] other;
        logic tx_fault;
        logic rx_los;
    } mfi_flags_t;

    typedef struct packed {
        logic fast_los;
        logic tx_disable;
    } mfi_ctrl_t;

    typedef struct packed {
        logic wr;
        logic [7:0] off;
    } mfi_aphase_t;

    typedef enum logic [2:0] {
        MFI_INIT = 3'b001,
        MFI_RUN = 3'b010,
        MFI_HELD = 3'b100
    } mfi_state_t;

endpackage

// file: rtl/mfi_top.sv
// Module flag latching, masking, interrupt pin, reset and init window
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mfi_defines.svh"

module mfi_top #(
    parameter int INIT_CYCLES = `MFI_INIT_CYC,
    parameter int RST_CYCLES = `MFI_RST_CYC,
    parameter int LOS_FILT = `MFI_LOS_FILT
) (
    input wire logic I_CLK,                  // 250 MHz clock
    input wire logic I_RESET_N,              // Async power-on reset
    input wire logic I_MODULE_RESET_N,       // Host module reset pin
    input wire logic I_RX_LOS,               // Receive loss condition
    input wire logic I_TX_FAULT,             // Transmitter fault condition
    input wire logic [5:0] I_OTHER_FLAG,     // Other flag conditions
    input wire logic I_HSEL,                 // AHB select
    input wire logic [31:0] I_HADDR,         // AHB address
    input wire logic [1:0] I_HTRANS,         // AHB transfer type
    input wire logic I_HWRITE,               // AHB write
    input wire logic [2:0] I_HSIZE,          // AHB size
    input wire logic [31:0] I_HWDATA,        // AHB write data
    input wire logic I_HREADY,               // AHB ready
    output logic [31:0] O_HRDATA,            // AHB read data
    output logic O_HREADYOUT,                // AHB ready out
    output logic O_HRESP,                    // AHB response
    output logic O_HOST_INTERRUPT_N,         // Interrupt pin, low active
    output logic O_TX_ENABLE,                // Transmitter on
    output logic O_RX_LOS,                   // Live receive-loss indication
    output logic O_MANAGEMENT_INIT_STATE     // High during init window
);

    if (INIT_CYCLES < 2 || RST_CYCLES < 1 || LOS_FILT < 1 || LOS_FILT > 255) begin : g_bad
        $error("mfi_top: parameter out of range");
    end

    mfi_pkg::mfi_state_t state;
    mfi_pkg::mfi_state_t next_state;
    mfi_pkg::mfi_flags_t status;
    mfi_pkg::mfi_flags_t next_status;
    mfi_pkg::mfi_flags_t mask;
    mfi_pkg::mfi_flags_t set_ev;
    mfi_pkg::mfi_ctrl_t ctrl;
    mfi_pkg::mfi_aphase_t aph;
    logic [31:0] init_cnt;
    logic [31:0] rst_cnt;
    logic [7:0] los_cnt;
    logic [31:0] rdata;
    logic int_n;
    logic tx_en;
    logic los_out;

    // Bus decode
    wire logic [7:0] off = I_HADDR[7:0];
    wire logic acc = I_HSEL && I_HTRANS[1] && I_HREADY;
    wire logic rd_acc = acc && !I_HWRITE;
    wire logic rd_stat = rd_acc && (off == `MFI_OFF_STATUS);
    wire logic wr_mask = aph.wr && (aph.off == `MFI_OFF_MASK);
    wire logic wr_ctrl = aph.wr && (aph.off == `MFI_OFF_CTRL);
    wire logic run = (state == mfi_pkg::MFI_RUN);
    wire logic held = (state == mfi_pkg::MFI_HELD);
    // An exactly minimum-length pulse must count as a request
    wire logic rst_full = (rst_cnt == 32'(RST_CYCLES - 1));
    wire logic init_end = (init_cnt == 32'(INIT_CYCLES - 1));
    wire logic los_full = (los_cnt == 8'(LOS_FILT));
    wire logic los_live = I_RX_LOS && (ctrl.fast_los || los_full);
    wire logic [3:0] live = {I_TX_FAULT, tx_en, los_live, !O_MANAGEMENT_INIT_STATE};
    wire logic [31:0] next_rdata =
        (off == `MFI_OFF_STATUS) ? {24'h000000, status} :
        (off == `MFI_OFF_MASK) ? {24'h000000, mask} :
        (off == `MFI_OFF_CTRL) ? {30'h00000000, ctrl} :
        (off == `MFI_OFF_STATE) ? {28'h0000000, live} : 32'h00000000;

    // conditions latch only in normal operation
    assign set_ev = run ? {I_OTHER_FLAG, I_TX_FAULT, los_live} : 8'h00;
    assign next_status = (rd_stat ? 8'h00 : status) | set_ev;

    // long low pulse holds module, release starts init
    always_comb begin
        case (state)
            mfi_pkg::MFI_INIT: next_state = init_end ? mfi_pkg::MFI_RUN : mfi_pkg::MFI_INIT;
            mfi_pkg::MFI_RUN: next_state = mfi_pkg::MFI_RUN;
            mfi_pkg::MFI_HELD: next_state = I_MODULE_RESET_N ? mfi_pkg::MFI_INIT
                                                              : mfi_pkg::MFI_HELD;
            default: next_state = mfi_pkg::MFI_INIT;
        endcase
        if (!I_MODULE_RESET_N && rst_full) begin
            next_state = mfi_pkg::MFI_HELD;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state <= mfi_pkg::MFI_INIT;
            rst_cnt <= 32'h00000000;
        end else begin
            state <= next_state;
            rst_cnt <= I_MODULE_RESET_N ? 32'h00000000 : (rst_full ? rst_cnt : rst_cnt + 32'h1);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            init_cnt <= 32'h00000000;
        end else begin
            init_cnt <= (state == mfi_pkg::MFI_INIT) ? init_cnt + 32'h1 : 32'h00000000;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            los_cnt <= 8'h00;
        end else begin
            los_cnt <= !I_RX_LOS ? 8'h00 : (los_full ? los_cnt : los_cnt + 8'h01);
        end
    end

    // Held module loses its settings
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            status <= `MFI_RST_FLAGS;
            mask <= `MFI_RST_MASK;
            ctrl <= `MFI_RST_CTRL;
        end else if (held) begin
            status <= `MFI_RST_FLAGS;
            mask <= `MFI_RST_MASK;
            ctrl <= `MFI_RST_CTRL;
        end else begin
            status <= next_status;
            if (wr_mask) begin
                mask <= I_HWDATA[7:0];
            end
            if (wr_ctrl) begin
                ctrl <= I_HWDATA[1:0];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aph <= '0;
            rdata <= 32'h00000000;
        end else begin
            aph.wr <= acc && I_HWRITE;
            aph.off <= off;
            if (rd_acc) begin
                rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            int_n <= 1'b1;
            tx_en <= 1'b0;
            los_out <= 1'b0;
        end else begin
            int_n <= !(|(status & ~mask));
            tx_en <= run && !ctrl.tx_disable;
            los_out <= los_live;
        end
    end

    // Zero wait states keep the clear-on-read capture exact
    assign O_HRDATA = rdata;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_HOST_INTERRUPT_N = int_n;
    assign O_TX_ENABLE = tx_en;
    assign O_RX_LOS = los_out;
    assign O_MANAGEMENT_INIT_STATE = (state == mfi_pkg::MFI_INIT);

    // Exact-cycle checks; the stated limits are far looser
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    property p_rst_hold;
        !I_MODULE_RESET_N && !held && rst_cnt == 32'(RST_CYCLES - 1)
            |=> !I_MODULE_RESET_N |-> held;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("long reset pulse not taken");

    property p_init_bound;
        O_MANAGEMENT_INIT_STATE |-> init_cnt < 32'(INIT_CYCLES);
    endproperty
    a_init_bound: assert property (p_init_bound) else $error("init window too long");

    property p_irq_on;
        (|(set_ev & ~mask)) && !held && !wr_mask ##1 !held
            |=> !O_HOST_INTERRUPT_N;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt not asserted");

    property p_irq_off;
        rd_stat && set_ev == 8'h00 && !held |-> ##2 O_HOST_INTERRUPT_N;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt not released");

    property p_los_set;
        (I_RX_LOS && run && !held) [*5] |=> status.rx_los;
    endproperty
    a_los_set: assert property (p_los_set) else $error("loss flag not set");

    property p_los_fast;
        ctrl.fast_los && I_RX_LOS && run |=> status.rx_los;
    endproperty
    a_los_fast: assert property (p_los_fast) else $error("fast loss flag late");

    property p_los_clear;
        !I_RX_LOS |=> !O_RX_LOS;
    endproperty
    a_los_clear: assert property (p_los_clear) else $error("loss not withdrawn");

    property p_fault_set;
        I_TX_FAULT && run |=> status.tx_fault;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

    property p_other_set;
        run && I_OTHER_FLAG != 6'h00 |=> (status.other & $past(I_OTHER_FLAG)) == $past(I_OTHER_FLAG);
    endproperty
    a_other_set: assert property (p_other_set) else $error("other flag not set");

    property p_masked;
        (status & ~mask) == 8'h00 |=> O_HOST_INTERRUPT_N;
    endproperty
    a_masked: assert property (p_masked) else $error("masked flag interrupts");

    property p_unmasked;
        (|(status & ~mask)) |=> !O_HOST_INTERRUPT_N;
    endproperty
    a_unmasked: assert property (p_unmasked) else $error("unmasked flag silent");

    property p_txdis;
        ctrl.tx_disable |=> !O_TX_ENABLE;
    endproperty
    a_txdis: assert property (p_txdis) else $error("transmitter not off");

    property p_txen;
        run && !ctrl.tx_disable |=> O_TX_ENABLE;
    endproperty
    a_txen: assert property (p_txen) else $error("transmitter not on");

    property p_irq_hold;
        !O_HOST_INTERRUPT_N && !$past(rd_stat) && !$past(held) && !$past(wr_mask)
            |=> !O_HOST_INTERRUPT_N;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");

    // Register and reset side effects
    property p_set_wins;
        rd_stat && !held |=> status == $past(set_ev);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("read clear lost an event");

    property p_rdata;
        rd_stat |=> O_HRDATA == {24'h000000, $past(status)};
    endproperty
    a_rdata: assert property (p_rdata) else $error("status read data wrong");

    property p_mask_wr;
        wr_mask && !held |=> mask == $past(I_HWDATA[7:0]);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    property p_held_clear;
        held |=> status == 8'h00 && mask == 8'h00 && ctrl == 2'h0;
    endproperty
    a_held_clear: assert property (p_held_clear) else $error("held kept settings");

    property p_rst_short;
        !held && !(!I_MODULE_RESET_N && rst_full) |=> !held;
    endproperty
    a_rst_short: assert property (p_rst_short) else $error("short pulse taken as reset");

    property p_init_exit;
        O_MANAGEMENT_INIT_STATE && init_end && !(!I_MODULE_RESET_N && rst_full)
            |=> run;
    endproperty
    a_init_exit: assert property (p_init_exit) else $error("init window not closed");

    property p_held_tx;
        held |=> !O_TX_ENABLE;
    endproperty
    a_held_tx: assert property (p_held_tx) else $error("transmitter on while held");

    c_irq: cover property (O_HOST_INTERRUPT_N ##1 !O_HOST_INTERRUPT_N);
    c_read_clear: cover property (rd_stat && status != 8'h00 ##2 O_HOST_INTERRUPT_N);
    c_mod_reset: cover property (held ##1 O_MANAGEMENT_INIT_STATE);
    c_txdis: cover property (O_TX_ENABLE ##1 ctrl.tx_disable ##1 !O_TX_ENABLE);
    c_fast_los: cover property (ctrl.fast_los && I_RX_LOS && run ##1 status.rx_los);

endmodule

`default_nettype wire

// file: tb/mfi_host_model.sv
// Host controller model: AHB-Lite master reaching the flag block
`timescale 1ns/1ps
`default_nettype none
module mfi_host_model (
    input wire logic i_clk,           // Clock
    input wire logic i_hready,        // Bus ready
    input wire logic [31:0] i_hrdata, // Read data
    output logic o_hsel,              // Select
    output logic [31:0] o_haddr,      // Address
    output logic [1:0] o_htrans,      // Transfer type
    output logic o_hwrite,            // Write
    output logic [2:0] o_hsize,       // Always a word
    output logic [31:0] o_hwdata      // Write data
);
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end
    // No bound of its own: the bench watchdog ends a hung wait
    task automatic wait_ready();
        do begin
            @(posedge i_clk);
        end while (i_hready !== 1'b1);
    endtask
    task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge i_clk);
        o_hsel <= 1'b1;
        o_htrans <= 2'h2;
        o_haddr <= {24'h0, off};
        o_hwrite <= wr;
        wait_ready();
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        // Reads put the inverse on the data lines, never a stale value
        o_hwdata <= wr ? wd : ~o_hwdata;
        wait_ready();
        rd = i_hrdata;
    endtask
endmodule
`default_nettype wire

// file: tb/mfi_top_tb.sv
// Self-checking bench of the flag and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "mfi_defines.svh"
module mfi_top_tb;
    localparam int INIT = 20;
    localparam logic [7:0] ROWS [5] = '{8'h01, 8'h02, 8'h04, 8'h80, 8'h7f};
    logic clk, reset_n, mrst_n, hsel, hwrite, hready, hresp, int_n, tx_en, los, init_st;
    logic [7:0] cond;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int num_errors = 0;
    int n_compared = 0;
    mfi_top #(.INIT_CYCLES(INIT), .RST_CYCLES(4), .LOS_FILT(4)) mfi_top_i (
        .I_CLK(clk), .I_RESET_N(reset_n), .I_MODULE_RESET_N(mrst_n),
        .I_RX_LOS(cond[0]), .I_TX_FAULT(cond[1]), .I_OTHER_FLAG(cond[7:2]),
        .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HOST_INTERRUPT_N(int_n),
        .O_TX_ENABLE(tx_en), .O_RX_LOS(los), .O_MANAGEMENT_INIT_STATE(init_st));
    mfi_host_model mfi_host_model_i (
        .i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));
    initial clk = 1'b0;
    always #2 clk = ~clk;
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] off, input logic [31:0] exp, input string what);
        logic [31:0] d;
        mfi_host_model_i.xfer(1'b0, off, 32'h0, d);
        chk_word(d, exp, what);
    endtask
    task automatic wr(input logic [7:0] off, input logic [31:0] v);
        logic [31:0] d;
        mfi_host_model_i.xfer(1'b1, off, v, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic settle(input int n);
        cyc(n);
        @(negedge clk);
    endtask
    // Host reset pulse of k edges
    task automatic pulse_reset(input int k);
        @(posedge clk);
        mrst_n <= 1'b0;
        cyc(k);
        mrst_n <= 1'b1;
    endtask
    initial begin
        reset_n = 1'b0;
        mrst_n = 1'b1;
        cond = 8'h00;
        settle(1);
        chk_bit(int_n, 1'b1, "int in reset");
        chk_bit(init_st, 1'b1, "init in reset");
        @(posedge clk);
        reset_n <= 1'b1;
        settle(INIT + 3);
        chk_bit(init_st, 1'b0, "init done");
        chk_bit(tx_en, 1'b1, "tx on");
        chk_bit(hresp, 1'b0, "okay");
        chk_bit(hready, 1'b1, "no wait states");
        rd(`MFI_OFF_STATE, 32'h5, "state live");
        rd(`MFI_OFF_MASK, 32'h0, "mask reset");
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h0, "unmapped");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            cond <= ROWS[i];
            cyc(10);
            cond <= 8'h00;
            @(negedge clk);
            chk_bit(los, ROWS[i][0], "live loss");
            chk_bit(int_n, 1'b0, "int set");
            rd(`MFI_OFF_STATUS, {24'h0, ROWS[i]}, "status");
            settle(2);
            chk_bit(int_n, 1'b1, "int cleared");
            chk_bit(los, 1'b0, "loss withdrawn");
            rd(`MFI_OFF_STATUS, 32'h0, "status cleared");
        end
        // Mask applied to a flag that is already pending
        @(posedge clk);
        cond <= 8'h04;
        cyc(3);
        cond <= 8'h00;
        wr(`MFI_OFF_MASK, 32'h04);
        settle(2);
        chk_bit(int_n, 1'b1, "masked");
        wr(`MFI_OFF_MASK, 32'h0);
        settle(2);
        chk_bit(int_n, 1'b0, "unmasked");
        rd(`MFI_OFF_STATUS, 32'h04, "status masked");
        // Single-cycle loss only counts in fast mode
        wr(`MFI_OFF_CTRL, 32'h02);
        @(posedge clk);
        cond <= 8'h01;
        @(posedge clk);
        cond <= 8'h00;
        settle(3);
        chk_bit(int_n, 1'b0, "fast loss");
        rd(`MFI_OFF_STATUS, 32'h01, "fast status");
        wr(`MFI_OFF_CTRL, 32'h01);
        settle(2);
        chk_bit(tx_en, 1'b0, "tx disabled");
        wr(`MFI_OFF_CTRL, 32'h0);
        settle(2);
        chk_bit(tx_en, 1'b1, "tx enabled");
        wr(`MFI_OFF_CTRL, 32'h01);
        pulse_reset(3);
        settle(3);
        chk_bit(init_st, 1'b0, "short pulse");
        pulse_reset(4);
        settle(3);
        chk_bit(init_st, 1'b1, "reset taken");
        settle(INIT + 3);
        chk_bit(init_st, 1'b0, "reinit done");
        chk_bit(tx_en, 1'b1, "tx after reset");
        rd(`MFI_OFF_CTRL, 32'h0, "ctrl cleared");
        // Power-on reset in mid-run
        wr(`MFI_OFF_MASK, 32'hff);
        @(posedge clk);
        reset_n <= 1'b0;
        settle(1);
        chk_bit(init_st, 1'b1, "init in second reset");
        chk_bit(tx_en, 1'b0, "tx off in reset");
        chk_bit(int_n, 1'b1, "int in second reset");
        @(posedge clk);
        reset_n <= 1'b1;
        settle(INIT + 3);
        chk_bit(init_st, 1'b0, "init after reset");
        rd(`MFI_OFF_MASK, 32'h0, "mask after reset");
        tally_and_finish();
    end
    initial begin
        #(4 * 5000);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
